// File: wdrt_map.svh
/*
 * Register indices, field positions, reset values and codes of the
 * watchdog and periodic interrupt control block.
 * Assumes it is included by its bare name before any use.
 */
`ifndef WDRT_MAP_SVH
`define WDRT_MAP_SVH

// ============================================================
// Register indices (byte address is four times the index)
`define WDRT_IDX_PCNT     16'h7021
`define WDRT_IDX_DCNT     16'h7023
`define WDRT_IDX_KEY      16'h7025
`define WDRT_IDX_PCTRL    16'h7027
`define WDRT_IDX_DCTRL    16'h7029

// ============================================================
// Field positions
`define WDRT_BIT_FLAG     7
`define WDRT_BIT_EN       6
`define WDRT_CHK_HI       5
`define WDRT_CHK_LO       3
`define WDRT_RATE_HI      2

// ============================================================
// Reset values and codes
`define WDRT_RST_PCTRL    8'h00
`define WDRT_RST_DCTRL    8'h00
`define WDRT_RST_CNT      8'h00
`define WDRT_CHK_OK       3'h5
`define WDRT_KEY_ARM      8'h55
`define WDRT_KEY_FIRE     8'hAA

// ============================================================
// Counter widths and taps
`define WDRT_FREE_W       14
`define WDRT_PTICK_SHIFT  4'h7
`define WDRT_DCNT_MAX     8'hFF

`endif

// File: wdrt_pkg.sv
/*
 * Types and shared helpers of the watchdog and periodic interrupt block.
 * Assumes wdrt_map.svh is on the include path.
 */
package wdrt_pkg;
`include "wdrt_map.svh"

    // ========================================================
    // Bus handshake states
    typedef enum logic [0:0] {
        BUS_IDLE   = 1'b0,
        BUS_ANSWER = 1'b1
    } wdrt_bus_state_t;

    typedef logic [`WDRT_FREE_W-1:0] wdrt_free_t;

    // True when the lowest n bits are all ones (the tap is about to wrap)
    function automatic logic wdrt_low_ones(input wdrt_free_t v,
                                           input logic [3:0] n);
        wdrt_free_t mask;
        mask = wdrt_free_t'((15'h0001 << n) - 15'h0001);
        return &(v | ~mask);
    endfunction : wdrt_low_ones

    // Watchdog rate code to free-counter tap, codes 00x share divide by 1
    function automatic logic [3:0] wdrt_dog_shift(input logic [2:0] code);
        return (code < 3'h2) ? 4'h0 : {1'b0, code - 3'h1};
    endfunction : wdrt_dog_shift

endpackage : wdrt_pkg

// File: wdrt_tap_if.sv
/*
 * Slow-clock tick and free-running prescale count shared between modules.
 * Assumes a single system clock; all signals are synchronous to it.
 */
`timescale 1ns/1ns
interface wdrt_tap_if;
    import wdrt_pkg::*;
    logic       slow_edge;
    wdrt_free_t free;

    modport src (output slow_edge, output free);
    modport snk (input slow_edge, input free);
endinterface : wdrt_tap_if

// File: wdrt_prescale.sv
/*
 * Slow timer clock synchroniser and free-running prescale counter.
 * Assumes slow_timer_clock is far slower than clk.
 */
`timescale 1ns/1ns
module wdrt_prescale
    import wdrt_pkg::*;
(
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic slow_timer_clock,
    wdrt_tap_if.src   tap
);
    logic       sync1;
    logic       sync2;
    logic       sync3;
    wdrt_free_t free;
    wdrt_free_t next_free;

    // ========================================================
    // Counter next value, cleared only by system reset
    always_comb begin
        next_free = free;
        if (sync2 && !sync3) begin
            next_free = free + 1'b1;
        end
    end

    // Two-flop synchroniser, third flop only for edge detection
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            sync3 <= 1'b0;
            free  <= '0;
        end else begin
            sync1 <= slow_timer_clock;
            sync2 <= sync1;
            sync3 <= sync2;
            free  <= next_free;
        end
    end

    assign tap.slow_edge = sync2 && !sync3;
    assign tap.free      = free;

    // ========================================================
    // Checks
    a_free_counts: assert property (
        @(posedge clk) disable iff (!arst_n)
        tap.slow_edge |=> free == $past(free) + 1'b1)
        else $error("free counter missed a slow edge");
    a_free_holds: assert property (
        @(posedge clk) disable iff (!arst_n)
        !tap.slow_edge |=> $stable(free))
        else $error("free counter moved without a slow edge");
endmodule : wdrt_prescale

// File: wdrt_dog.sv
/*
 * Watchdog counter, key sequence and system reset request.
 * Assumes key_wr and force_rst are one-cycle pulses from the bus logic.
 */
`timescale 1ns/1ns
module wdrt_dog
    import wdrt_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       arst_n,
    wdrt_tap_if.snk         tap,
    input  wire logic       run,
    input  wire logic [2:0] rate_sel,
    input  wire logic       key_wr,
    input  wire logic [7:0] key_data,
    input  wire logic       force_rst,
    output logic      [7:0] counter,
    output logic            reset_req
);
    logic       dog_tick;
    logic       armed;
    logic       ovf;
    logic       next_armed;
    logic       next_ovf;
    logic       next_req;
    logic [7:0] next_cnt;

    assign dog_tick = tap.slow_edge &&
        wdrt_low_ones(tap.free, wdrt_dog_shift(rate_sel));

    // ========================================================
    // Key, count and reset decisions; request stays until reset
    always_comb begin
        next_armed = armed;
        next_ovf   = ovf;
        next_cnt   = counter;
        next_req   = reset_req || force_rst;
        if (run && dog_tick) begin
            if (ovf) begin
                next_req = 1'b1;
            end else begin
                next_cnt = counter + 1'b1;
                next_ovf = (counter == `WDRT_DCNT_MAX);
            end
        end
        // Clear wins over a coincident counting tick; a coincident tick after overflow still requests reset
        if (key_wr) begin
            if (key_data == `WDRT_KEY_ARM) begin
                next_armed = 1'b1;
            end else if (key_data == `WDRT_KEY_FIRE) begin
                if (armed) begin
                    next_cnt = `WDRT_RST_CNT;
                    next_ovf = 1'b0;
                end
                next_armed = 1'b0;
            end else begin
                next_req = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            armed     <= 1'b0;
            ovf       <= 1'b0;
            counter   <= `WDRT_RST_CNT;
            reset_req <= 1'b0;
        end else begin
            armed     <= next_armed;
            ovf       <= next_ovf;
            counter   <= next_cnt;
            reset_req <= next_req;
        end
    end

    // ========================================================
    // Checks
    a_ovf_then_reset: assert property (
        @(posedge clk) disable iff (!arst_n)
        run && dog_tick && ovf |=> reset_req)
        else $error("overflow did not request reset");
    a_bad_key_reset: assert property (
        @(posedge clk) disable iff (!arst_n)
        key_wr && key_data != `WDRT_KEY_ARM && key_data != `WDRT_KEY_FIRE
        |=> reset_req)
        else $error("bad key did not request reset");
    a_key_clears: assert property (
        @(posedge clk) disable iff (!arst_n)
        key_wr && key_data == `WDRT_KEY_FIRE && armed
        |=> counter == `WDRT_RST_CNT && !ovf)
        else $error("key sequence did not clear counter");
    c_dog_fires: cover property (@(posedge clk) disable iff (!arst_n)
        $rose(reset_req));
endmodule : wdrt_dog

// File: wdrt_top.sv
/*
 * Watchdog and periodic interrupt control: Avalon-MM register slave,
 * periodic counter, rate taps, flags and interrupt request.
 * Assumes one 100 MHz clock, an Avalon master honouring waitrequest,
 * a system that answers sys_reset_req by pulsing arst_n, and
 * por_arst_n that only power-on asserts.
 */
// Contract
// - Overflow sets flag bit 7; write zero clears
// - Software flag set raises no interrupt request
// - Enable bit 6 gates and cancels requests
// - One request per leading edge of tap
// - Fast rates from prescaler, slow via counter
// - Periodic reserved bits ignore writes, read zero
// - Periodic rate code picks divider 4..16384
// - Dog flag set only by dog reset
// - Disable bit acts only with high voltage
// - Check bits must be 101, else reset
// - Check bits always read back as zero
// - Dog rate code picks divider 1..64
// - Dog counts 257 prescaled clocks before reset
// - Prescaler free-runs, cleared only by reset
// - Key 55h then AAh clears; other resets
// - One more prescaled clock after dog overflow
// - Periodic counter on /128 tap, write clears
// - Key register read returns dog control
`timescale 1ns/1ns
module wdrt_top
    import wdrt_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        por_arst_n,
    input  wire logic        slow_timer_clock,
    input  wire logic        high_voltage_present,
    input  wire logic        irq_ack,
    input  wire logic [17:0] address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    output logic             irq_req,
    output logic             sys_reset_req
);
    wdrt_tap_if tap ();

    wdrt_bus_state_t state;
    wdrt_bus_state_t next_state;
    logic [31:0]     next_rdata;
    logic [7:0]      rd_byte;
    logic            wr_do;
    logic [7:0]      wd;
    logic            wr_pcnt;
    logic            wr_key;
    logic            wr_pctrl;
    logic            wr_dctrl;
    logic            check_err;

    logic            p_flag;
    logic            p_en;
    logic [2:0]      p_rate;
    logic [7:0]      p_cnt;
    logic            next_p_flag;
    logic            next_p_en;
    logic [2:0]      next_p_rate;
    logic [7:0]      next_p_cnt;
    logic            next_irq;
    logic            p_tick;
    logic            p_event;

    logic            d_flag;
    logic            d_dis;
    logic [2:0]      d_rate;
    logic            next_d_flag;
    logic            next_d_dis;
    logic [2:0]      next_d_rate;
    logic [7:0]      d_cnt;
    logic            d_run;

    // True when the byte address hits the given register index
    function automatic logic hit(input logic [17:0] a,
                                 input logic [15:0] idx);
        return a == {idx, 2'b00};
    endfunction : hit

    // ========================================================
    // Prescaler and watchdog
    wdrt_prescale i_wdrt_prescale (
        .clk              (clk),
        .arst_n           (arst_n),
        .slow_timer_clock (slow_timer_clock),
        .tap              (tap.src)
    );

    wdrt_dog i_wdrt_dog (
        .clk       (clk),
        .arst_n    (arst_n),
        .tap       (tap.snk),
        .run       (d_run),
        .rate_sel  (d_rate),
        .key_wr    (wr_key),
        .key_data  (wd),
        .force_rst (check_err),
        .counter   (d_cnt),
        .reset_req (sys_reset_req)
    );

    // Disable honoured only with high voltage present
    assign d_run = !(high_voltage_present && d_dis);

    // ========================================================
    // Bus slave: one wait cycle, data captured in the first one
    assign waitrequest = (read || write) && state != BUS_ANSWER;
    assign wr_do    = write && state == BUS_ANSWER && byteenable[0];
    assign wd       = writedata[7:0];
    assign wr_pcnt  = wr_do && hit(address, `WDRT_IDX_PCNT);
    assign wr_key   = wr_do && hit(address, `WDRT_IDX_KEY);
    assign wr_pctrl = wr_do && hit(address, `WDRT_IDX_PCTRL);
    assign wr_dctrl = wr_do && hit(address, `WDRT_IDX_DCTRL);
    assign check_err = wr_dctrl &&
        wd[`WDRT_CHK_HI:`WDRT_CHK_LO] != `WDRT_CHK_OK;

    // Read mux; unmapped addresses read zero
    always_comb begin
        rd_byte = 8'h00;
        if (hit(address, `WDRT_IDX_PCNT)) begin
            rd_byte = p_cnt;
        end else if (hit(address, `WDRT_IDX_DCNT)) begin
            rd_byte = d_cnt;
        end else if (hit(address, `WDRT_IDX_PCTRL)) begin
            rd_byte = {p_flag, p_en, 3'h0, p_rate};
        end else if (hit(address, `WDRT_IDX_DCTRL) ||
                     hit(address, `WDRT_IDX_KEY)) begin
            rd_byte = {d_flag, d_dis, 3'h0, d_rate};
        end
    end

    // Bus state and read data next values
    always_comb begin
        next_state = state;
        next_rdata = readdata;
        unique case (state)
            BUS_IDLE: begin
                if (read || write) begin
                    next_state = BUS_ANSWER;
                end
                if (read) begin
                    next_rdata = {24'h000000, rd_byte};
                end
            end
            BUS_ANSWER: begin
                next_state = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state    <= BUS_IDLE;
            readdata <= 32'h00000000;
        end else begin
            state    <= next_state;
            readdata <= next_rdata;
        end
    end

    // ========================================================
    // Periodic taps: fast codes straight off the prescaler
    assign p_tick = tap.slow_edge &&
        wdrt_low_ones(tap.free, `WDRT_PTICK_SHIFT);

    always_comb begin
        unique case (p_rate)
            3'h0: p_event = tap.slow_edge &&
                            wdrt_low_ones(tap.free, 4'h2);
            3'h1: p_event = tap.slow_edge &&
                            wdrt_low_ones(tap.free, 4'h4);
            3'h2: p_event = tap.slow_edge &&
                            wdrt_low_ones(tap.free, 4'h6);
            3'h3: p_event = p_tick;
            3'h4: p_event = p_tick &&
                            wdrt_low_ones({6'h00, p_cnt}, 4'h1);
            3'h5: p_event = p_tick &&
                            wdrt_low_ones({6'h00, p_cnt}, 4'h2);
            3'h6: p_event = p_tick &&
                            wdrt_low_ones({6'h00, p_cnt}, 4'h4);
            3'h7: p_event = p_tick &&
                            wdrt_low_ones({6'h00, p_cnt}, 4'h7);
        endcase
    end

    // Periodic registers; hardware set wins over software clear
    always_comb begin
        next_p_cnt  = p_cnt;
        next_p_flag = p_flag;
        next_p_en   = p_en;
        next_p_rate = p_rate;
        if (wr_pcnt) begin
            next_p_cnt = `WDRT_RST_CNT;
        end else if (p_tick) begin
            next_p_cnt = p_cnt + 1'b1;
        end
        if (wr_pctrl) begin
            next_p_flag = wd[`WDRT_BIT_FLAG];
            next_p_en   = wd[`WDRT_BIT_EN];
            next_p_rate = wd[`WDRT_RATE_HI:0];
        end
        if (p_event) begin
            next_p_flag = 1'b1;
        end
        // Only overflows request; flag state is irrelevant here
        next_irq = next_p_en &&
            (p_event || (irq_req && !irq_ack));
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            p_cnt   <= `WDRT_RST_CNT;
            p_flag  <= 1'(`WDRT_RST_PCTRL >> `WDRT_BIT_FLAG);
            p_en    <= 1'(`WDRT_RST_PCTRL >> `WDRT_BIT_EN);
            p_rate  <= 3'(`WDRT_RST_PCTRL);
            irq_req <= 1'b0;
        end else begin
            p_cnt   <= next_p_cnt;
            p_flag  <= next_p_flag;
            p_en    <= next_p_en;
            p_rate  <= next_p_rate;
            irq_req <= next_irq;
        end
    end

    // ========================================================
    // Dog control fields
    always_comb begin
        next_d_dis  = d_dis;
        next_d_rate = d_rate;
        if (wr_dctrl) begin
            next_d_dis  = wd[`WDRT_BIT_EN];
            next_d_rate = wd[`WDRT_RATE_HI:0];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            d_dis  <= 1'(`WDRT_RST_DCTRL >> `WDRT_BIT_EN);
            d_rate <= 3'(`WDRT_RST_DCTRL);
        end else begin
            d_dis  <= next_d_dis;
            d_rate <= next_d_rate;
        end
    end

    // Dog flag lives on power-on reset so it survives its own reset
    always_comb begin
        next_d_flag = d_flag;
        if (wr_dctrl && !wd[`WDRT_BIT_FLAG]) begin
            next_d_flag = 1'b0;
        end
        if (sys_reset_req) begin
            next_d_flag = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge por_arst_n) begin
        if (!por_arst_n) begin
            d_flag <= 1'b0;
        end else begin
            d_flag <= next_d_flag;
        end
    end

    // ========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_flag_on_event: assert property (
        p_event |=> p_flag)
        else $error("overflow did not set flag");
    a_sw_set_quiet: assert property (
        wr_pctrl && wd[`WDRT_BIT_FLAG] && !p_event && !irq_req
        |=> !irq_req)
        else $error("software flag set raised a request");
    a_irq_each_event: assert property (
        p_event && p_en && !wr_pctrl |=> irq_req)
        else $error("enabled overflow gave no request");
    a_disable_cancel: assert property (
        wr_pctrl && !wd[`WDRT_BIT_EN] |=> !irq_req ##1 !irq_req)
        else $error("request survived disable");
    a_ptick_rate: assert property (
        p_tick |-> tap.free[6:0] == 7'h7F)
        else $error("periodic counter tick off the 128 tap");
    a_check_err_rst: assert property (
        check_err |=> sys_reset_req)
        else $error("bad check bits did not reset");
    // Counters use every bit, so only control and key reads are judged
    a_rsvd_zero: assert property (
        read && state == BUS_ANSWER && (hit(address, `WDRT_IDX_PCTRL) ||
        hit(address, `WDRT_IDX_DCTRL) || hit(address, `WDRT_IDX_KEY))
        |-> readdata[5:3] == 3'h0)
        else $error("reserved or check bits read non-zero");
    a_key_mirror: assert property (
        read && state == BUS_IDLE && hit(address, `WDRT_IDX_KEY)
        |=> readdata[7:0] == $past(rd_byte) &&
            readdata[2:0] == $past(d_rate))
        else $error("key read did not mirror dog control");
    a_wait_one: assert property (
        (read || write) && state == BUS_IDLE |=> !waitrequest)
        else $error("answer took more than one wait cycle");
    a_dog_flag_set: assert property (
        sys_reset_req |=> d_flag)
        else $error("dog reset did not set flag");

    c_irq_served: cover property (irq_req ##1 irq_ack);
    c_slow_rate: cover property (p_event && p_rate == 3'h7);
    c_key_pair: cover property (
        wr_key && wd == `WDRT_KEY_ARM ##[1:20] wr_key && wd == `WDRT_KEY_FIRE);
    c_dog_disabled: cover property (!d_run && tap.slow_edge);
endmodule : wdrt_top

// File: wdrt_core_model.sv
/*
 * Core-side model: Avalon-MM master that issues register cycles.
 * Assumes a slave that ends each request by dropping waitrequest.
 */
`timescale 1ns/1ns
module wdrt_core_model (
    input  wire logic        clk,
    input  wire logic [31:0] readdata,
    input  wire logic        waitrequest,
    output logic      [17:0] address,
    output logic             read,
    output logic             write,
    output logic      [31:0] writedata,
    output logic      [3:0]  byteenable
);
`include "wdrt_map.svh"
    // ========================================================
    // Idle bus
    initial begin
        address    = 18'h00000;
        read       = 1'b0;
        write      = 1'b0;
        writedata  = 32'h00000000;
        byteenable = 4'h0;
    end

    // Request held until waitrequest is seen low at an edge
    task automatic xfer(input logic wr, input logic [15:0] idx,
                        input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        address    <= {idx, 2'b00};
        read       <= ~wr;
        write      <= wr;
        writedata  <= {24'h000000, d};
        byteenable <= 4'hF;
        do @(posedge clk); while (waitrequest !== 1'b0);
        q = readdata[7:0];
        read  <= 1'b0;
        write <= 1'b0;
    endtask : xfer

    // Key pair; a lone second key would be ignored
    task automatic kick();
        logic [7:0] q;
        xfer(1'b1, `WDRT_IDX_KEY, `WDRT_KEY_ARM, q);
        xfer(1'b1, `WDRT_IDX_KEY, `WDRT_KEY_FIRE, q);
    endtask : kick

    // Control writes always carry the check pattern
    task automatic dog_ctrl(input logic [7:0] d);
        logic [7:0] q;
        xfer(1'b1, `WDRT_IDX_DCTRL, {d[7:6], `WDRT_CHK_OK, d[2:0]}, q);
        // Check field forced above
    endtask : dog_ctrl
endmodule : wdrt_core_model

// File: wdrt_top_tb.sv
/*
 * Self-checking bench of the watchdog and periodic interrupt block.
 * Assumes the core model above; slow clock runs at a quarter of clk.
 */
`timescale 1ns/1ns
module wdrt_top_tb;
`include "wdrt_map.svh"
    logic        clk;
    logic        arst_n;
    logic        por_arst_n;
    logic        slow_timer_clock;
    logic        high_voltage_present;
    logic        irq_ack;
    logic [17:0] address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        irq_req;
    logic        sys_reset_req;
    logic [1:0]  slow_div;
    int          cyc;
    int          mismatches;
    int          check_count;

    // ========================================================
    // Clocks; slow clock kept short so long dividers stay cheap
    always #5 clk = ~clk;
    always @(posedge clk) begin
        slow_div         <= slow_div + 2'h1;
        slow_timer_clock <= slow_div[1];
        cyc              <= cyc + 1;
    end

    wdrt_top i_wdrt_top (.clk(clk), .arst_n(arst_n),
        .por_arst_n(por_arst_n), .slow_timer_clock(slow_timer_clock),
        .high_voltage_present(high_voltage_present), .irq_ack(irq_ack),
        .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest),
        .irq_req(irq_req), .sys_reset_req(sys_reset_req));
    wdrt_core_model i_wdrt_core_model (.clk(clk), .readdata(readdata),
        .waitrequest(waitrequest), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable));

    // ========================================================
    // Helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic rd(input logic [15:0] idx, output logic [7:0] q);
        i_wdrt_core_model.xfer(1'b0, idx, 8'h00, q);
    endtask : rd

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        logic [7:0] q;
        i_wdrt_core_model.xfer(1'b1, idx, d, q);
    endtask : wr

    // Bounded wait; running out counts as a mismatch
    task automatic wait_irq(output int t);
        int n;
        n = 0;
        while (irq_req !== 1'b1 && n < 40000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 40000) mismatches++;
        t = cyc;
    endtask : wait_irq

    task automatic ack();
        irq_ack <= 1'b1;
        @(posedge clk);
        irq_ack <= 1'b0;
        @(posedge clk);
    endtask : ack

    task automatic pulse_rst();
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
    endtask : pulse_rst

    // ========================================================
    // Scenarios
    task automatic t_reset_vals();
        logic [7:0] q;
        rd(`WDRT_IDX_PCTRL, q);
        chk(q, 8'h00);
        rd(`WDRT_IDX_DCTRL, q);
        chk(q, 8'h00);
        rd(16'h7020, q);
        chk(q, 8'h00);
    endtask : t_reset_vals

    task automatic t_dog_timeout();
        int n;
        logic [7:0] q;
        i_wdrt_core_model.kick();
        n = 0;
        while (sys_reset_req !== 1'b1 && n < 1200) begin
            @(posedge clk);
            n++;
        end
        chk(32'(n >= 1020 && n <= 1036), 32'h1);
        pulse_rst();
        rd(`WDRT_IDX_DCTRL, q);
        chk(q, 8'h80);
    endtask : t_dog_timeout

    task automatic t_dog_off();
        int n;
        logic [7:0] q;
        i_wdrt_core_model.dog_ctrl(8'h40);
        rd(`WDRT_IDX_DCTRL, q);
        chk(q, 8'h40);
        rd(`WDRT_IDX_KEY, q);
        chk(q, 8'h40);
        i_wdrt_core_model.kick();
        repeat (1500) @(posedge clk);
        chk(sys_reset_req, 1'b0);
        // Without high voltage the disable bit is void; code 010 halves ticks
        high_voltage_present <= 1'b0;
        i_wdrt_core_model.dog_ctrl(8'h42);
        i_wdrt_core_model.kick();
        n = 0;
        while (sys_reset_req !== 1'b1 && n < 2200) begin
            @(posedge clk);
            n++;
        end
        chk(32'(n >= 2040 && n <= 2072), 32'h1);
        high_voltage_present <= 1'b1;
        pulse_rst();
        // Periodic scenarios run long, so the dog is parked again
        i_wdrt_core_model.dog_ctrl(8'h40);
    endtask : t_dog_off

    // Spacing of two requests for rate codes 0 to 6; flag deliberately left set
    task automatic t_periodic();
        int t0;
        int t1;
        logic [7:0] q;
        int div [7] = '{4, 16, 64, 128, 256, 512, 2048};
        for (int r = 0; r < 7; r++) begin
            wr(`WDRT_IDX_PCTRL, 8'h00);
            wr(`WDRT_IDX_PCTRL, 8'h40 | 8'(r));
            wait_irq(t0);
            ack();
            rd(`WDRT_IDX_PCTRL, q);
            chk(q, 8'hC0 | 8'(r));
            wait_irq(t1);
            ack();
            chk(t1 - t0, div[r] * 4);
        end
    endtask : t_periodic

    task automatic t_cancel();
        int t0;
        logic [7:0] q;
        wr(`WDRT_IDX_PCTRL, 8'h40);
        wait_irq(t0);
        wr(`WDRT_IDX_PCTRL, 8'h00);
        @(posedge clk);
        chk(irq_req, 1'b0);
        wr(`WDRT_IDX_PCTRL, 8'hFF);
        repeat (8) @(posedge clk);
        chk(irq_req, 1'b0);
        rd(`WDRT_IDX_PCTRL, q);
        chk(q, 8'hC7);
        wr(`WDRT_IDX_PCNT, 8'h5A);
        rd(`WDRT_IDX_PCNT, q);
        chk(q, 8'h00);
    endtask : t_cancel

    task automatic t_bad_writes();
        logic [7:0] q;
        i_wdrt_core_model.xfer(1'b1, `WDRT_IDX_KEY, 8'h12, q);
        repeat (2) @(posedge clk);
        chk(sys_reset_req, 1'b1);
        pulse_rst();
        i_wdrt_core_model.xfer(1'b1, `WDRT_IDX_DCTRL, 8'h60, q);
        repeat (2) @(posedge clk);
        chk(sys_reset_req, 1'b1);
        pulse_rst();
    endtask : t_bad_writes

    // ========================================================
    // Verdict and run control
    task automatic summarize();
        if (mismatches == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : summarize

    initial begin
        repeat (80000) @(posedge clk);
        mismatches++;
        summarize();
    end

    initial begin
        clk                  = 1'b0;
        arst_n               = 1'b0;
        por_arst_n           = 1'b0;
        slow_timer_clock     = 1'b0;
        high_voltage_present = 1'b1;
        irq_ack              = 1'b0;
        slow_div             = 2'h0;
        cyc                  = 0;
        mismatches           = 0;
        check_count          = 0;
        repeat (6) @(posedge clk);
        arst_n     <= 1'b1;
        por_arst_n <= 1'b1;
        t_reset_vals();
        t_dog_timeout();
        t_dog_off();
        t_periodic();
        t_cancel();
        t_bad_writes();
        summarize();
    end
endmodule : wdrt_top_tb
